// ### include/temp_cfg_defines.svh
`ifndef TEMP_CFG_DEFINES_SVH
`define TEMP_CFG_DEFINES_SVH

// ----------------------------------------
// Pointer codes (two low pointer bits)
// ----------------------------------------
`define PTR_TEMP 2'h0
`define PTR_CFG 2'h1
`define PTR_LOWER 2'h2
`define PTR_UPPER 2'h3

// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define CFG_SHUTDOWN_BIT 0
`define CFG_THERMO_BIT 1
`define CFG_POLARITY_BIT 2
`define CFG_F_LO 3
`define CFG_F_HI 4
`define CFG_RES_LO 5
`define CFG_RES_HI 6
`define CFG_OS_BIT 7
`define CFG_EXT_BIT 12
`define CFG_ALARM_BIT 13
`define CFG_CR_LO 14
`define CFG_CR_HI 15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SHUTDOWN 1'h0
`define RST_THERMO 1'h0
`define RST_POLARITY 1'h0
`define RST_FAULT 2'h0
`define RST_EXT 1'h0
`define RST_RATE 2'h2
`define RST_PTR 2'h0
`define RST_UPPER 16'h5000
`define RST_LOWER 16'h4B00

// ----------------------------------------
// Conversion intervals in ms, clock in cycles per ms
// ----------------------------------------
`define PER_RATE0_MS 4000
`define PER_RATE1_MS 1000
`define PER_RATE2_MS 250
`define PER_RATE3_MS 125
`define CLK_MHZ 125
`define CYC_PER_MS (`CLK_MHZ * 1000)

`endif

// ### include/temp_cfg_pkg.sv
package temp_cfg_pkg;

    // Host access, decoded from the two-wire transaction layer
    typedef struct packed {
        logic ptr_wr;
        logic wr;
        logic rd;
        logic [15:0] data;
    } host_req_t;

endpackage : temp_cfg_pkg

// ### core/fault_qualifier.sv
`timescale 1ns/1ps
module fault_qualifier
    import temp_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sample_i,
    input wire logic over_i,
    input wire logic under_i,
    input wire logic [2:0] need_i,
    output logic active_o
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic active_d;
    wire logic hit = active_o ? under_i : over_i;
    wire logic [2:0] cnt_inc = cnt_q + 3'h1;

    // ----------------------------------------
    // Consecutive-fault hysteresis
    // ----------------------------------------
    always_comb begin
        cnt_d = cnt_q;
        active_d = active_o;
        if (sample_i) begin
            if (!hit) begin
                cnt_d = 3'h0;
            end else if (cnt_inc >= need_i) begin
                cnt_d = 3'h0;
                active_d = !active_o;
            end else begin
                cnt_d = cnt_inc;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= 3'h0;
            active_o <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            active_o <= active_d;
        end
    end
endmodule : fault_qualifier

// ### core/temp_sensor_config_alarm.sv
`timescale 1ns/1ps
`include "temp_cfg_defines.svh"
// Function
// - Shutdown bit 1 stops, 0 converts continuously
// - Rate field picks 0.25/1/4/8 Hz
// - Flag drops after upper-limit faults, polarity 0
// - Flag holds until lower-limit faults clear it
// - Polarity 1 inverts the flag
// - Thermostat mode never touches the flag
// - Same polarity rule in every mode
// - Fault field needs 1, 2, 4, 6
// - Extended select switches 12/13-bit formats
module temp_sensor_config_alarm
    import temp_cfg_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = `CYC_PER_MS
) (
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    input wire host_req_t HOST_REQ_I,
    input wire logic TEMP_VALID_I,
    input wire logic [12:0] TEMP_I,
    output logic [15:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    output logic CONV_START_O
);
    localparam int unsigned PER0 = `PER_RATE0_MS * CYC_PER_MS;
    localparam int unsigned PER1 = `PER_RATE1_MS * CYC_PER_MS;
    localparam int unsigned PER2 = `PER_RATE2_MS * CYC_PER_MS;
    localparam int unsigned PER3 = `PER_RATE3_MS * CYC_PER_MS;

    logic [1:0] ptr_q;
    logic shutdown_select_q, thermostat_mode_sel_q;
    logic alert_polarity_q, extended_range_sel_q, busy_q;
    logic [1:0] fault_q, rate_q;
    logic [15:0] upper_q, lower_q;
    logic signed [12:0] temp_q;
    logic [31:0] tmr_q;
    logic [31:0] tmr_d;
    logic alarm_active;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    wire logic [1:0] sel = ptr_q;
    wire logic wr_cfg = HOST_REQ_I.wr && !HOST_REQ_I.ptr_wr && sel == `PTR_CFG;
    wire logic wr_up = HOST_REQ_I.wr && sel == `PTR_UPPER;
    wire logic wr_lo = HOST_REQ_I.wr && sel == `PTR_LOWER;
    wire logic [1:0] rate_new = HOST_REQ_I.data[`CFG_CR_HI:`CFG_CR_LO];
    wire logic rate_rewrite = wr_cfg;
    wire logic alarm_flag = alert_polarity_q ? alarm_active : !alarm_active;
    wire logic [15:0] cfg_rd = {rate_q, alarm_flag, extended_range_sel_q, 4'h0,
                                !busy_q, 2'h3, fault_q, alert_polarity_q,
                                thermostat_mode_sel_q, shutdown_select_q};
    wire logic [15:0] temp_rd = extended_range_sel_q ? {temp_q, 3'h1} :
                                {temp_q[11:0], 4'h0};
    wire logic [15:0] rd_mux = (sel == `PTR_TEMP) ? temp_rd :
                               (sel == `PTR_CFG) ? cfg_rd :
                               (sel == `PTR_LOWER) ? lower_q : upper_q;

    // ----------------------------------------
    // Limit compare in the active format
    // ----------------------------------------
    wire logic signed [12:0] up_v = extended_range_sel_q ? upper_q[15:3] :
                                    {upper_q[15], upper_q[15:4]};
    wire logic signed [12:0] lo_v = extended_range_sel_q ? lower_q[15:3] :
                                    {lower_q[15], lower_q[15:4]};
    wire logic signed [12:0] t_v = extended_range_sel_q ? $signed(TEMP_I) :
                                   {TEMP_I[11], TEMP_I[11:0]};
    wire logic over = t_v >= up_v;
    wire logic under = t_v < lo_v;
    wire logic [2:0] need = (fault_q == 2'h0) ? 3'h1 : (fault_q == 2'h1) ? 3'h2 :
                            (fault_q == 2'h2) ? 3'h4 : 3'h6;

    // ----------------------------------------
    // Conversion timer
    // ----------------------------------------
    wire logic [1:0] rate_eff = rate_rewrite ? rate_new : rate_q;
    wire logic [31:0] reload = (rate_eff == 2'h0) ? PER0 : (rate_eff == 2'h1) ? PER1 :
                               (rate_eff == 2'h2) ? PER2 : PER3;
    wire logic fire = !shutdown_select_q && tmr_q == 32'h0 && !rate_rewrite;

    always_comb begin
        tmr_d = tmr_q - 32'h1;
        if (shutdown_select_q || rate_rewrite || tmr_q == 32'h0) begin
            tmr_d = reload - 32'h1;
        end
    end

    // Interval counts from the first cycle after the rewrite, so a stale
    // count never fires at the old rate
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tmr_q <= 32'h0;
            CONV_START_O <= 1'b0;
            busy_q <= 1'b1;
        end else begin
            tmr_q <= tmr_d;
            CONV_START_O <= fire;
            busy_q <= fire | (busy_q & !TEMP_VALID_I);
        end
    end

    // ----------------------------------------
    // Configuration and limit registers
    // ----------------------------------------
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ptr_q <= `RST_PTR;
            shutdown_select_q <= `RST_SHUTDOWN;
            thermostat_mode_sel_q <= `RST_THERMO;
            alert_polarity_q <= `RST_POLARITY;
            fault_q <= `RST_FAULT;
            extended_range_sel_q <= `RST_EXT;
            rate_q <= `RST_RATE;
        end else if (HOST_REQ_I.ptr_wr) begin
            ptr_q <= HOST_REQ_I.data[1:0];
        end else if (wr_cfg) begin
            shutdown_select_q <= HOST_REQ_I.data[`CFG_SHUTDOWN_BIT];
            thermostat_mode_sel_q <= HOST_REQ_I.data[`CFG_THERMO_BIT];
            alert_polarity_q <= HOST_REQ_I.data[`CFG_POLARITY_BIT];
            fault_q <= HOST_REQ_I.data[`CFG_F_HI:`CFG_F_LO];
            extended_range_sel_q <= HOST_REQ_I.data[`CFG_EXT_BIT];
            rate_q <= rate_new;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            upper_q <= `RST_UPPER;
            lower_q <= `RST_LOWER;
        end else begin
            if (wr_up && !HOST_REQ_I.ptr_wr) upper_q <= HOST_REQ_I.data;
            if (wr_lo && !HOST_REQ_I.ptr_wr) lower_q <= HOST_REQ_I.data;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            temp_q <= 13'h0000;
            REG_RDATA_O <= 16'h0000;
            REG_RVALID_O <= 1'b0;
        end else begin
            if (TEMP_VALID_I) temp_q <= TEMP_I;
            REG_RVALID_O <= HOST_REQ_I.rd;
            if (HOST_REQ_I.rd) REG_RDATA_O <= rd_mux;
        end
    end

    // Alarm moves only on conversion results; mode bit is not an input
    fault_qualifier u_fault (
        .clk_i(SYS_CLK_I),
        .rstn_i(RSTN_I),
        .sample_i(TEMP_VALID_I),
        .over_i(over),
        .under_i(under),
        .need_i(need),
        .active_o(alarm_active)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    wire logic rd_cfg = HOST_REQ_I.rd && sel == `PTR_CFG && !HOST_REQ_I.ptr_wr;
    wire logic rd_tmp = HOST_REQ_I.rd && sel == `PTR_TEMP && !HOST_REQ_I.ptr_wr;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RSTN_I);

    property p_shutdown_quiet;
        $past(shutdown_select_q) |-> !CONV_START_O;
    endproperty
    a_shutdown_quiet: assert property (p_shutdown_quiet) else $error("conversion in shutdown");

    property p_rate_rd;
        rd_cfg |=> REG_RDATA_O[15:14] == $past(rate_q) && REG_RVALID_O;
    endproperty
    a_rate_rd: assert property (p_rate_rd) else $error("rate readback wrong");

    property p_trip;
        !alarm_active && TEMP_VALID_I && over && need == 3'h1 |=> alarm_active;
    endproperty
    a_trip: assert property (p_trip) else $error("alarm did not trip");

    property p_hold;
        alarm_active && !(TEMP_VALID_I && under) |=> alarm_active;
    endproperty
    a_hold: assert property (p_hold) else $error("alarm released early");

    property p_polarity_rd;
        rd_cfg |=> REG_RDATA_O[13] == ($past(alert_polarity_q) ~^ $past(alarm_active));
    endproperty
    a_polarity_rd: assert property (p_polarity_rd) else $error("flag polarity wrong");

    property p_no_sample_still;
        !TEMP_VALID_I |=> $stable(alarm_active);
    endproperty
    a_no_sample_still: assert property (p_no_sample_still) else $error("alarm moved");

    property p_idle_reads_one;
        rd_cfg && !alert_polarity_q && !alarm_active |=> REG_RDATA_O[13];
    endproperty
    a_idle_reads_one: assert property (p_idle_reads_one) else $error("idle flag");

    property p_six;
        fault_q == 2'h3 |-> need == 3'h6;
    endproperty
    a_six: assert property (p_six) else $error("fault count map");

    property p_ext_tag;
        rd_tmp |=> REG_RDATA_O[0] == $past(extended_range_sel_q);
    endproperty
    a_ext_tag: assert property (p_ext_tag) else $error("format tag wrong");

    property p_restart;
        wr_cfg && !HOST_REQ_I.ptr_wr |=> !CONV_START_O ##1 !CONV_START_O;
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted");

    c_trip: cover property (!alarm_active ##1 alarm_active);
    c_clear: cover property (alarm_active ##1 !alarm_active);
    c_conv: cover property (CONV_START_O);
    c_polarity: cover property (rd_cfg && alert_polarity_q);
endmodule : temp_sensor_config_alarm

// ### bench/host_model.sv
`timescale 1ns/1ps
module host_model
    import temp_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output host_req_t req_o
);
    // Idle data after a write is the inverse of the written word, so a stale word never looks valid
    initial req_o = '0;

    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        req_o <= '{1'b1, 1'b0, 1'b0, {14'h0, a}};
        @(posedge clk_i);
        req_o <= '{1'b0, 1'b1, 1'b0, d};
        @(posedge clk_i);
        req_o <= '{1'b0, 1'b0, 1'b0, ~d};
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        d = 'x;
        @(posedge clk_i);
        req_o <= '{1'b1, 1'b0, 1'b0, {14'h0, a}};
        @(posedge clk_i);
        req_o <= '{1'b0, 1'b0, 1'b1, {14'h3FFF, ~a}};
        @(posedge clk_i);
        req_o <= '{1'b0, 1'b0, 1'b0, {14'h0, a}};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_i);
            if (rvalid_i === 1'b1) begin
                d = rdata_i;
                break;
            end
        end
    endtask : rd_reg
endmodule : host_model

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int CPM = 2;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic tv = 1'b0;
    logic [12:0] t = 13'h0;
    logic [12:0] v;
    temp_cfg_pkg::host_req_t req;
    logic [15:0] rdat;
    logic [15:0] got;
    logic rv;
    logic cs;
    int error_cnt = 0;
    int cmp_count = 0;
    int seed = 32'h998d;
    int act = 0;
    int cnt = 0;
    int nd = 1;
    int m;
    int n;
    int need[4] = '{1, 2, 4, 6};
    int per[4] = '{4000, 1000, 250, 125};

    initial forever #4 clk = ~clk;

    temp_sensor_config_alarm #(.CYC_PER_MS(CPM)) uut (.SYS_CLK_I(clk), .RSTN_I(rstn),
        .HOST_REQ_I(req), .TEMP_VALID_I(tv), .TEMP_I(t), .REG_RDATA_O(rdat),
        .REG_RVALID_O(rv), .CONV_START_O(cs));
    host_model host (.clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .req_o(req));

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // ----------------------------------------
    // Reference alarm: counts consecutive faults
    // ----------------------------------------
    task automatic samp(input logic [12:0] s);
        @(posedge clk);
        t <= s;
        tv <= 1'b1;
        @(posedge clk);
        tv <= 1'b0;
        if (act == 0) cnt = (s[11:0] >= 12'h500) ? cnt + 1 : 0;
        else cnt = (s[11:0] < 12'h4B0) ? cnt + 1 : 0;
        if (cnt == nd) begin
            act = 1 - act;
            cnt = 0;
        end
    endtask : samp

    // Busy bit is masked: it follows conversions the bench does not close
    task automatic cfg_chk(input int f, input int p);
        host.rd_reg(2'h1, got);
        chk(got & 16'hFF7F, {2'b10, p ? act[0] : ~act[0], 5'h0, 3'b011, f[1:0], p[0], m[0], 1'b0});
    endtask : cfg_chk

    initial begin
        #480000;
        error_cnt++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        host.rd_reg(2'h1, got);
        chk(got & 16'hFF7F, 16'hA060);
        $display("test reset done");
        for (int p = 0; p < 2; p++) begin
            for (int f = 0; f < 4; f++) begin
                m = $random(seed) & 1;
                nd = need[f];
                host.wr_reg(2'h1, {8'h80, 3'h0, f[1:0], p[0], m[0], 1'b0});
                samp(13'h04B0);
                for (int i = 1; i < nd; i++) samp(13'h0500);
                samp(13'h04B0);
                for (int i = 1; i < nd; i++) samp(13'h0500);
                cfg_chk(f, p);
                samp(13'h0500);
                cfg_chk(f, p);
                samp(13'h04B0);
                cfg_chk(f, p);
                repeat (nd) samp(13'h04AF);
                cfg_chk(f, p);
            end
        end
        $display("test alarm done");
        host.wr_reg(2'h1, 16'hC001);
        repeat (2) @(negedge clk);
        n = 0;
        repeat (600) @(negedge clk) n += cs;
        chk(n[15:0], 16'h0);
        for (int r = 0; r < 4; r++) begin
            host.wr_reg(2'h1, {r[1:0], 14'h0});
            n = 0;
            do begin @(negedge clk); n++; end while (cs !== 1'b1 && n < 20000);
            n = 0;
            do begin @(negedge clk); n++; end while (cs !== 1'b1 && n < 20000);
            chk(n[15:0], 16'(per[r] * CPM));
        end
        $display("test rate done");
        v = 13'($random(seed));
        samp(v);
        host.wr_reg(2'h0, 16'hFFFF);
        host.rd_reg(2'h0, got);
        chk(got, {v[11:0], 4'h0});
        host.wr_reg(2'h1, 16'h9000);
        v = 13'($random(seed));
        samp(v);
        host.rd_reg(2'h0, got);
        chk(got, {v, 3'b001});
        $display("test format done");
        results();
    end
endmodule : tb_top
